// ---- inc/iob_pkg.sv ----
package iob_pkg;

    // ------------------------------------------------------------------
    // Address layout
    // ------------------------------------------------------------------
    localparam int          ADDR_W         = 10;
    localparam int          BASE_LSB       = 5;
    localparam int          BASE_W         = 5;
    localparam logic [4:0]  OFS_PORT0_LO   = 5'h00;
    localparam logic [4:0]  OFS_PORT0_HI   = 5'h07;
    localparam logic [4:0]  OFS_PORT1_LO   = 5'h08;
    localparam logic [4:0]  OFS_PORT1_HI   = 5'h0F;
    localparam logic [4:0]  OFS_IRQ_STAT   = 5'h10;
    localparam int          IRQ_LEVELS     = 13;
    localparam int          IRQ_FIRST      = 3;
    localparam logic [7:0]  RST_DATA       = 8'h00;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        IOB_DIR_IDLE = 2'b00,
        IOB_DIR_TX   = 2'b01,
        IOB_DIR_RX   = 2'b11
    } iob_dir_e;

    typedef enum logic [1:0] {
        IOB_SEL_NONE  = 2'b00,
        IOB_SEL_PORT0 = 2'b01,
        IOB_SEL_PORT1 = 2'b10,
        IOB_SEL_STAT  = 2'b11
    } iob_sel_e;

    // Host register request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
        logic              wr;
        logic              rd;
        logic              dma;
    } iob_req_s;

    // Link-side pins of one port
    typedef struct packed {
        logic tx_data;
        logic tx_en;
        logic rx_en;
    } iob_line_s;

    // Local access towards a serial controller
    typedef struct packed {
        logic [2:0] reg_ofs;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } iob_ctl_s;

endpackage

// ---- src/iob_dec.sv ----
`timescale 1ns/10ps
module iob_dec (
    input  wire logic                       i_clk,
    input  wire logic                       i_nrst,
    input  wire logic [iob_pkg::ADDR_W-1:0] i_addr,
    input  wire logic                       i_io_cyc,
    input  wire logic [4:0]                 i_base_jmp,
    output logic                            o_hit,
    output iob_pkg::iob_sel_e               o_sel
);

    // ------------------------------------------------------------------
    // Combinational window decode
    // ------------------------------------------------------------------
    logic [4:0] base;
    logic [4:0] ofs;

    always_comb begin
        // Fitted jumper (1) means the bit must be zero
        base  = ~i_base_jmp;                                          // RULE_01 RULE_03
        ofs   = i_addr[iob_pkg::BASE_LSB-1:0];                        // RULE_04
        o_hit = i_io_cyc
              && (i_addr[iob_pkg::ADDR_W-1:iob_pkg::BASE_LSB] == base); // RULE_02 RULE_12
        if (!o_hit) begin
            o_sel = iob_pkg::IOB_SEL_NONE;
        end else if (ofs <= iob_pkg::OFS_PORT0_HI) begin
            o_sel = iob_pkg::IOB_SEL_PORT0;                           // RULE_13
        end else if (ofs <= iob_pkg::OFS_PORT1_HI) begin
            o_sel = iob_pkg::IOB_SEL_PORT1;                           // RULE_13
        end else if (ofs == iob_pkg::OFS_IRQ_STAT) begin
            o_sel = iob_pkg::IOB_SEL_STAT;                            // RULE_14
        end else begin
            o_sel = iob_pkg::IOB_SEL_NONE;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    window_match_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_01
        o_hit |-> (i_addr[9:5] == ~i_base_jmp) && i_io_cyc)
        else $error("window hit with wrong upper address");

endmodule // iob_dec

// ---- src/iob_line.sv ----
`timescale 1ns/10ps
module iob_line (
    input  wire logic          i_clk,
    input  wire logic          i_nrst,
    input  wire logic          i_half_duplex_jumper,
    input  wire logic          i_full_duplex_jumper,
    input  wire logic          i_tx_req,
    input  wire logic          i_tx_data,
    output iob_pkg::iob_line_s o_line
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        iob_pkg::iob_dir_e  dir;
        iob_pkg::iob_line_s line;
    } iob_line_state_s;

    iob_line_state_s st;
    iob_line_state_s next_st;
    logic            half;

    // Both jumpers fitted is a four-wire slave: shared bus, so one way at a time
    assign half = i_half_duplex_jumper;

    always_comb begin
        next_st              = st;
        next_st.line.tx_data = i_tx_data;
        if (half) begin
            next_st.dir = i_tx_req ? iob_pkg::IOB_DIR_TX : iob_pkg::IOB_DIR_RX; // RULE_06 RULE_10
            next_st.line.tx_en = i_tx_req;                                      // RULE_10
            next_st.line.rx_en = !i_tx_req;                                     // RULE_10
        end else if (i_full_duplex_jumper) begin
            next_st.dir        = iob_pkg::IOB_DIR_IDLE;
            next_st.line.tx_en = 1'b1;                                          // RULE_07 RULE_11
            next_st.line.rx_en = 1'b1;                                          // RULE_11
        end else begin
            next_st.dir        = iob_pkg::IOB_DIR_IDLE;
            next_st.line.tx_en = 1'b0;
            next_st.line.rx_en = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_line = st.line;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    half_exclusive_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_10
        $past(half) |-> !(o_line.tx_en && o_line.rx_en))
        else $error("half duplex port drives and listens together");

    full_both_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_11
        $past(!half && i_full_duplex_jumper) |-> (o_line.tx_en && o_line.rx_en))
        else $error("full duplex port not open both ways");

    half_follows_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_06
        (half && i_tx_req) |=> o_line.tx_en)
        else $error("half duplex transmit not enabled");

endmodule // iob_line

// ---- src/iob_top.sv ----
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/10ps
// What this block does
// (RULE_01) Fitted base jumper demands a zero address bit; absent jumper demands one.
// (RULE_02) Base is selectable anywhere from 000 to 3E0 hex.
// (RULE_03) Lines A9..A5 weigh 200,100,80,40,20 hex; absent jumpers sum.
// (RULE_04) Address bits 4..0 never join the base match; they pick registers.
// (RULE_05) One jumper-chosen interrupt level, 3 to 15, serves both ports.
// (RULE_06) Half-duplex jumper fitted gives a two-wire half-duplex port.
// (RULE_07) Full-duplex jumper fitted gives a four-wire full-duplex port; code goes half-duplex if the half-duplex jumper is fitted too.
// (RULE_08) Installer fits only full-duplex jumper for a four-wire master.
// (RULE_09) Installer fits both jumpers for a four-wire slave.
// (RULE_10) Half-duplex port never sends and receives at once.
// (RULE_11) Full-duplex port sends and receives at the same time.
// (RULE_12) Select only on non-DMA I/O cycles with matching upper address.
// (RULE_13) Offsets 0-7 reach first port controller, 8-F the second.
// (RULE_14) Offset 10h reads status: bit 0 first port, bit 1 second.
module iob_top (
    input  wire logic                       i_clk,
    input  wire logic                       i_nrst,
    input  wire logic [iob_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [7:0]                 i_wdata,
    input  wire logic                       i_wr,
    input  wire logic                       i_rd,
    input  wire logic                       i_dma,
    input  wire logic [4:0]                 i_base_jmp,
    input  wire logic [12:0]                i_irq_jmp,
    input  wire logic [1:0]                 i_half_duplex_jumper,
    input  wire logic [1:0]                 i_full_duplex_jumper,
    input  wire logic [1:0]                 i_port_irq,
    input  wire logic [7:0]                 i_port0_rdata,
    input  wire logic [7:0]                 i_port1_rdata,
    input  wire logic [1:0]                 i_tx_req,
    input  wire logic [1:0]                 i_tx_data,
    output logic [7:0]                      o_rdata,
    output logic                            o_data_oe,
    output logic                            o_sel,
    output logic [12:0]                     o_irq,
    output iob_pkg::iob_ctl_s               o_port0_ctl,
    output iob_pkg::iob_ctl_s               o_port1_ctl,
    output iob_pkg::iob_line_s              o_line0,
    output iob_pkg::iob_line_s              o_line1
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]        rdata;
        logic              data_oe;
        logic              sel;
        logic [12:0]       irq;
        iob_pkg::iob_ctl_s ctl0;
        iob_pkg::iob_ctl_s ctl1;
        iob_pkg::iob_sel_e rd_sel;
    } iob_state_s;

    iob_state_s        st;
    iob_state_s        next_st;
    logic              hit;
    iob_pkg::iob_sel_e sel;
    logic              io_cyc;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    assign io_cyc = (i_wr || i_rd) && !i_dma;                         // RULE_12

    iob_dec u_dec (
        .i_clk      (i_clk),
        .i_nrst     (i_nrst),
        .i_addr     (i_addr),
        .i_io_cyc   (io_cyc),
        .i_base_jmp (i_base_jmp),
        .o_hit      (hit),
        .o_sel      (sel)
    );

    // ------------------------------------------------------------------
    // Line mode per port
    // ------------------------------------------------------------------
    iob_line u_line0 (
        .i_clk                (i_clk),
        .i_nrst               (i_nrst),
        .i_half_duplex_jumper (i_half_duplex_jumper[0]),
        .i_full_duplex_jumper (i_full_duplex_jumper[0]),
        .i_tx_req             (i_tx_req[0]),
        .i_tx_data            (i_tx_data[0]),
        .o_line               (o_line0)
    );

    iob_line u_line1 (
        .i_clk                (i_clk),
        .i_nrst               (i_nrst),
        .i_half_duplex_jumper (i_half_duplex_jumper[1]),
        .i_full_duplex_jumper (i_full_duplex_jumper[1]),
        .i_tx_req             (i_tx_req[1]),
        .i_tx_data            (i_tx_data[1]),
        .o_line               (o_line1)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    function automatic iob_pkg::iob_ctl_s mk_ctl(input logic en);
        iob_pkg::iob_ctl_s c;
        c.reg_ofs = i_addr[2:0];                                      // RULE_04
        c.wdata   = i_wdata;
        c.wr      = en && i_wr;
        c.rd      = en && i_rd;
        return c;
    endfunction

    always_comb begin
        next_st        = st;
        next_st.sel    = hit;                                          // RULE_12
        next_st.ctl0   = mk_ctl(sel == iob_pkg::IOB_SEL_PORT0);        // RULE_13
        next_st.ctl1   = mk_ctl(sel == iob_pkg::IOB_SEL_PORT1);        // RULE_13
        next_st.rd_sel = i_rd ? sel : iob_pkg::IOB_SEL_NONE;
        // Shared line: every jumpered level follows the OR of both ports
        next_st.irq    = (|i_port_irq) ? i_irq_jmp : 13'h0000;         // RULE_05
        // Read data stands only in the cycle after the strobe
        next_st.data_oe = hit && i_rd && (sel != iob_pkg::IOB_SEL_NONE); // RULE_12
        next_st.rdata   = iob_pkg::RST_DATA;
        case (sel)
            iob_pkg::IOB_SEL_PORT0: begin
                next_st.rdata = i_port0_rdata;                         // RULE_13
            end
            iob_pkg::IOB_SEL_PORT1: begin
                next_st.rdata = i_port1_rdata;                         // RULE_13
            end
            iob_pkg::IOB_SEL_STAT: begin
                next_st.rdata = {6'h00, i_port_irq};                   // RULE_14
            end
            default: begin
                next_st.rdata = 8'h00;
            end
        endcase
        if (!i_rd) begin
            next_st.rdata = 8'h00;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_rdata     = st.rdata;
    assign o_data_oe   = st.data_oe;
    assign o_sel       = st.sel;
    assign o_irq       = st.irq;
    assign o_port0_ctl = st.ctl0;
    assign o_port1_ctl = st.ctl1;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    no_dma_sel_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_12
        i_dma |=> !o_sel)
        else $error("board selected during DMA cycle");

    drive_on_read_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_12
        o_data_oe |-> $past(i_rd) && $past(hit))
        else $error("data driven without selected read");

    status_read_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_14
        (i_rd && sel == iob_pkg::IOB_SEL_STAT) |=> o_rdata == {6'h00, $past(i_port_irq)})
        else $error("status read mismatch");

    port0_route_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_13
        (hit && i_wr && i_addr[4:3] == 2'b00) |=> o_port0_ctl.wr && !o_port1_ctl.wr)
        else $error("low window not routed to first port");

    port1_route_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_13
        (hit && i_wr && i_addr[4:3] == 2'b01) |=> o_port1_ctl.wr && !o_port0_ctl.wr)
        else $error("upper window not routed to second port");

    low_bits_free_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_04
        (io_cyc && i_addr[9:5] == ~i_base_jmp) |-> hit)
        else $error("low address bits affected match");

    shared_irq_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_05
        (|i_port_irq) |=> o_irq == $past(i_irq_jmp))
        else $error("shared interrupt not raised");

    irq_quiet_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RULE_05
        !(|i_port_irq) |=> o_irq == 13'h0000)
        else $error("interrupt raised without request");

endmodule // iob_top

// ---- tb/iob_host.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Host bus master: one strobe cycle per access, address held with it
// ------------------------------------------------------------------
module iob_host (
    input  wire logic                       i_clk,
    output logic [iob_pkg::ADDR_W-1:0]      o_addr,
    output logic [7:0]                      o_wdata,
    output logic                            o_wr,
    output logic                            o_rd,
    output logic                            o_dma
);
    initial begin
        o_addr  = '0;
        o_wdata = 8'h00;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        o_dma   = 1'b0;
    end

    // Returns 1 ns after the edge that samples the strobe, when answers stand
    task automatic access(input logic [9:0] a, input logic w, input logic [7:0] d,
                          input logic dma);
        @(posedge i_clk);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= w;
        o_rd    <= !w;
        o_dma   <= dma;
        @(posedge i_clk);
        // Released lines carry garbage, not the last value
        o_addr  <= ~a;
        o_wdata <= ~d;
        o_wr    <= 1'b0;
        o_rd    <= 1'b0;
        o_dma   <= 1'b0;
        #1;
    endtask
endmodule // iob_host

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
    logic                  i_clk, i_nrst, wr, rd, dma;
    logic [9:0]            addr;
    logic [7:0]            wdata, o_rdata;
    logic [4:0]            base_jmp;
    logic [12:0]           irq_jmp, o_irq;
    logic [1:0]            hdj, fdj, port_irq, tx_req, tx_data;
    logic                  o_data_oe, o_sel;
    iob_pkg::iob_ctl_s     p0, p1;
    iob_pkg::iob_line_s    l0, l1;
    int                    n_errors, compares, cyc;

    // ------------------------------------------------------------------
    // Clock, timeout, instances
    // ------------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    initial cyc = 0;
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            stop_test();
        end
    end

    iob_host i_host (.i_clk(i_clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd),
                     .o_dma(dma));
    iob_top i_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .i_dma(dma), .i_base_jmp(base_jmp), .i_irq_jmp(irq_jmp),
        .i_half_duplex_jumper(hdj), .i_full_duplex_jumper(fdj), .i_port_irq(port_irq),
        .i_port0_rdata(8'h3C), .i_port1_rdata(8'hC3), .i_tx_req(tx_req),
        .i_tx_data(tx_data), .o_rdata(o_rdata), .o_data_oe(o_data_oe), .o_sel(o_sel),
        .o_irq(o_irq), .o_port0_ctl(p0), .o_port1_ctl(p1), .o_line0(l0), .o_line1(l1));

    // ------------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------------
    task automatic cmp(input logic [12:0] got, input logic [12:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("Mismatches %0d, comparisons %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        #1;
        cmp({o_sel, o_data_oe, o_rdata}, 13'h000, "reset outputs");
        cmp(o_irq, 13'h0000, "reset irq");
    endtask

    // Several jumper patterns, every window edge, every single-bit miss, DMA refusal
    task automatic t_decode();
        logic [4:0] pats [4] = '{5'h00, 5'h1F, 5'h07, 5'h15};
        logic [9:0] base;
        for (int p = 0; p < 4; p++) begin
            base = 10'h000;
            for (int b = 0; b < 5; b++) if (!pats[p][b]) base += 10'h020 << b;
            @(posedge i_clk);
            base_jmp <= pats[p];
            i_host.access(base | 10'h01F, 1'b1, 8'h5A, 1'b0);
            cmp(o_sel, 1'b1, "hit top of window");
            i_host.access(base, 1'b1, 8'hA5, 1'b0);
            cmp(o_sel, 1'b1, "hit bottom of window");
            for (int b = 0; b < 5; b++) begin
                i_host.access(base ^ (10'h020 << b), 1'b0, 8'h00, 1'b0);
                cmp({o_sel, o_data_oe}, 2'b00, "miss on one base bit");
            end
            i_host.access(base | 10'h003, 1'b1, 8'h11, 1'b1);
            cmp({o_sel, p0.wr}, 2'b00, "dma cycle selected");
        end
    endtask

    // Both boundaries of each controller range, writes and reads
    task automatic t_route();
        logic [4:0] ofs [4] = '{5'h00, 5'h07, 5'h08, 5'h0F};
        logic       w, hi;
        @(posedge i_clk);
        base_jmp <= 5'h18;
        for (int k = 0; k < 8; k++) begin
            w  = (k < 4);
            hi = ofs[k % 4][3];
            i_host.access(10'h0E0 | {5'h00, ofs[k % 4]}, w, 8'hA0 ^ k[7:0], 1'b0);
            cmp({p0.wr, p0.rd, p1.wr, p1.rd}, {!hi & w, !hi & !w, hi & w, hi & !w},
                "controller strobes");
            cmp(hi ? p1.reg_ofs : p0.reg_ofs, ofs[k % 4][2:0], "register offset");
            if (w) cmp(hi ? p1.wdata : p0.wdata, 8'hA0 ^ k[7:0], "write data");
            else begin
                cmp(o_data_oe, 1'b1, "read drives bus");
                cmp(o_rdata, hi ? 8'hC3 : 8'h3C, "controller read data");
            end
        end
    endtask

    // Status location, offset 11h above it, write to it, off-board read
    task automatic t_stat();
        @(posedge i_clk);
        base_jmp <= 5'h00;
        for (int v = 0; v < 4; v++) begin
            @(posedge i_clk);
            port_irq <= v[1:0];
            i_host.access(10'h3F0, 1'b0, 8'h00, 1'b0);
            cmp({o_data_oe, o_rdata}, {1'b1, 6'h00, v[1:0]}, "status read");
        end
        i_host.access(10'h3F1, 1'b0, 8'h00, 1'b0);
        cmp({o_data_oe, o_rdata}, 9'h000, "unused offset read");
        i_host.access(10'h3F0, 1'b1, 8'hFF, 1'b0);
        cmp({o_data_oe, p0.wr, p1.wr}, 3'b000, "status write");
        i_host.access(10'h1F0, 1'b0, 8'h00, 1'b0);
        cmp(o_data_oe, 1'b0, "off-board read drives bus");
    endtask

    // Every interrupt level, the requester cycling first port, second port, both
    task automatic t_irq();
        for (int k = 0; k < 13; k++) begin
            @(posedge i_clk);
            irq_jmp  <= 13'h0001 << k;
            port_irq <= 2'(k % 3 + 1);
            repeat (2) @(posedge i_clk);
            #1;
            cmp(o_irq, 13'h0001 << k, "shared irq level");
            port_irq <= 2'b00;
            repeat (2) @(posedge i_clk);
            #1;
            cmp(o_irq, 13'h0000, "irq idle");
        end
    endtask

    // {half, full, tx_req, tx_en, rx_en}; both jumpers is the four-wire slave set-up
    task automatic t_line();
        logic [4:0] tbl [7] = '{5'b10110, 5'b10001, 5'b01011, 5'b01111, 5'b11110,
                                5'b11001, 5'b00100};
        int j;
        for (int i = 0; i < 7; i++) begin
            j = (i + 3) % 7;
            @(posedge i_clk);
            hdj     <= {tbl[j][4], tbl[i][4]};
            fdj     <= {tbl[j][3], tbl[i][3]};
            tx_req  <= {tbl[j][2], tbl[i][2]};
            tx_data <= {tbl[i][2], tbl[j][2]};
            repeat (2) @(posedge i_clk);
            #1;
            cmp({l0.tx_en, l0.rx_en}, tbl[i][1:0], "first port mode");
            cmp({l1.tx_en, l1.rx_en}, tbl[j][1:0], "second port mode");
            cmp({l0.tx_data, l1.tx_data}, {tbl[j][2], tbl[i][2]}, "tx data path");
        end
    endtask

    initial begin
        n_errors = 0;
        compares = 0;
        i_nrst   = 1'b0;
        base_jmp = 5'h00;
        irq_jmp  = 13'h0001;
        hdj      = 2'b00;
        fdj      = 2'b00;
        port_irq = 2'b00;
        tx_req   = 2'b00;
        tx_data  = 2'b00;
        repeat (6) @(posedge i_clk);
        i_nrst <= 1'b1;
        @(posedge i_clk);
        t_reset();
        t_decode();
        t_route();
        t_stat();
        t_irq();
        t_line();
        stop_test();
    end
endmodule // tb_top
